//--- design/wta_consts.vh
// Constants for the watchdog and timed-access unlock block.
`ifndef WTA_CONSTS_VH
`define WTA_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define WTA_IDX_UNLOCK_KEY     10'h0c7
`define WTA_IDX_WD_CONTROL     10'h0d8
`define WTA_ADDR_UNLOCK_KEY    12'h31c
`define WTA_ADDR_WD_CONTROL    12'h360
`define WTA_ADDR_CTRL          12'h400
`define WTA_ADDR_IRQ_STATUS    12'h404
`define WTA_ADDR_IRQ_CLEAR     12'h408
`define WTA_ADDR_IRQ_ENABLE    12'h40c
`define WTA_ADDR_WD_COUNT      12'h410

// ----------------------------------------------------------------------
// Watchdog control field positions
// ----------------------------------------------------------------------
`define WTA_WD_BAUD_DOUBLE     7
`define WTA_WD_POWER_UP        6
`define WTA_WD_IRQ_FLAG        3
`define WTA_WD_RESET_CAUSE     2
`define WTA_WD_RESET_EN        1
`define WTA_WD_KICK            0
`define WTA_CTRL_IRQ_EN        0
`define WTA_CTRL_MOVX_WAIT     1

// ----------------------------------------------------------------------
// Unlock key values and event bits
// ----------------------------------------------------------------------
`define WTA_KEY_FIRST          8'haa
`define WTA_KEY_SECOND         8'h55
`define WTA_EV_TIMEOUT         0
`define WTA_EV_DOG_RESET       1
`define WTA_EV_UNLOCKED        2
`define WTA_EV_REFUSED         3
`define WTA_EV_BITS            4

// ----------------------------------------------------------------------
// Timing: machine cycles and the clocks derived from them
// ----------------------------------------------------------------------
`define WTA_CLKS_PER_MC        4
`define WTA_KEY_GAP_MC         3
`define WTA_WINDOW_MC          3
`define WTA_KEY_GAP_CLKS       (`WTA_KEY_GAP_MC * `WTA_CLKS_PER_MC)
`define WTA_WINDOW_CLKS        (`WTA_WINDOW_MC * `WTA_CLKS_PER_MC)
`define WTA_PRE_RESET_CLKS     512
`define WTA_TIMEOUT_CLKS       131072

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define WTA_RESP_OKAY          2'b00
`define WTA_RESP_SLVERR        2'b10

`endif

//--- design/wta_top.v
// Watchdog control with timed-access unlock, reached over AXI4-Lite.
//
// Contract
// [R1] Unlock needs key AAH then 55H written back to back; nothing else unlocks.
// [R2] A valid unlock opens protected writes for three machine cycles only.
// [R3] Power-up, reset enable, irq flag and kick bits change only inside the window.
// [R4] Every watchdog control bit reads back at any time without unlocking.
// [R5] Power-up flag set on power-up; once set, only software clears it.
// [R6] Time-out sets the watchdog irq flag; only software clears it. The code also clears it on an external reset.
// [R7] Watchdog reset sets reset-cause flag; software or power-fail clears it.
// [R8] A time-out resets the device only while reset enable is set.
// [R9] Writing the kick bit restarts the count; hardware clears the bit.
// [R10] Time-out raises interrupt when enabled, reset follows 512 clocks later.
// [R11] External reset loads 0x0x0xx0b; cause flag kept on external reset.
// [R12] Power-on reset sets power-up flag, clears reset enable; others keep it.
// [R13] Top bit doubles the second serial port baud rate; always writable.
// [R14] The wait-state enable bit changes only inside the unlock window.
// [R15] A 55H arriving more than three machine cycles after AAH opens nothing.
// [R16] Any other key write after AAH abandons the sequence.
// [R17] The time-out period is a design parameter.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "wta_consts.vh"

module wta_top #(
    parameter [31:0] TIMEOUT_CLKS = `WTA_TIMEOUT_CLKS
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ext_rst_pin,
    input  wire        pfail_pin,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        dog_reset_out,
    output wire        dog_irq_out,
    output wire        port1_baud_double,
    output wire        movx_wait_enable,
    output wire        irq
);

    // ------------------------------------------------------------------
    // Local definitions
    // ------------------------------------------------------------------
    localparam WD_RUN = 1'b0;
    localparam WD_PRE = 1'b1;
    localparam [31:0] TO_LAST  = TIMEOUT_CLKS - 32'd1;
    localparam [9:0]  PRE_LAST = 10'd`WTA_PRE_RESET_CLKS - 10'd1;
    localparam [3:0]  GAP_LAST = 4'd`WTA_KEY_GAP_MC * 4'd`WTA_CLKS_PER_MC - 4'd1;
    localparam [3:0]  WIN_LEN  = 4'd`WTA_WINDOW_MC * 4'd`WTA_CLKS_PER_MC;

    // Settled value of a pin after three flops: changes only on agreement.
    function settle;
        input s2;
        input s3;
        input cur;
        begin
            settle = (s2 == s3) ? s3 : cur;
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg  [1:0] pin_s1_q;
    reg  [1:0] pin_s2_q;
    reg  [1:0] pin_s3_q;
    reg  [1:0] pin_lvl_q;
    wire [1:0] pin_lvl_d;
    wire       ext_rst_evt;
    wire       pfail_evt;

    assign pin_lvl_d[0] = settle(pin_s2_q[0], pin_s3_q[0], pin_lvl_q[0]);
    assign pin_lvl_d[1] = settle(pin_s2_q[1], pin_s3_q[1], pin_lvl_q[1]);
    assign ext_rst_evt  = pin_lvl_d[0] & ~pin_lvl_q[0];
    assign pfail_evt    = pin_lvl_d[1] & ~pin_lvl_q[1];

    // Pins are async to clk, so only the second and third stages are compared.
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_q  <= 2'h0;
            pin_s2_q  <= 2'h0;
            pin_s3_q  <= 2'h0;
            pin_lvl_q <= 2'h0;
        end else begin
            pin_s1_q  <= {pfail_pin, ext_rst_pin};
            pin_s2_q  <= pin_s1_q;
            pin_s3_q  <= pin_s2_q;
            pin_lvl_q <= pin_lvl_d;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write and read channels
    // ------------------------------------------------------------------
    reg        aw_got_q;
    reg [11:0] awaddr_q;
    reg        w_got_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;
    wire       do_wr;
    wire       rd_take;
    wire       wr_b0;
    wire [7:0] wbyte;
    reg        wr_hit;
    reg        rd_hit;
    reg [31:0] rd_val;

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready  = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign do_wr   = aw_got_q & w_got_q & ~bvalid_q;
    assign rd_take = s_axi_arvalid & ~rvalid_q;
    assign wr_b0   = do_wr & wstrb_q[0];
    assign wbyte   = wdata_q[7:0];

    // Address and data may come in either order; the write commits once both are held.
    always @(posedge clk) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 12'h000;
            w_got_q  <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= `WTA_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `WTA_RESP_OKAY : `WTA_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read data is registered in the cycle the address is taken.
    always @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `WTA_RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_hit ? `WTA_RESP_OKAY : `WTA_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    wire wr_key  = wr_b0 & (awaddr_q == `WTA_ADDR_UNLOCK_KEY);
    wire wr_wdc  = wr_b0 & (awaddr_q == `WTA_ADDR_WD_CONTROL);
    wire wr_ctrl = wr_b0 & (awaddr_q == `WTA_ADDR_CTRL);
    wire wr_clr  = wr_b0 & (awaddr_q == `WTA_ADDR_IRQ_CLEAR);
    wire wr_ien  = wr_b0 & (awaddr_q == `WTA_ADDR_IRQ_ENABLE);

    // ------------------------------------------------------------------
    // Timed-access unlock sequencer
    // ------------------------------------------------------------------
    reg        armed_q;
    reg [3:0]  gap_q;
    reg [3:0]  win_q;
    wire       win_open;
    wire       key_open;

    assign win_open = (win_q != 4'h0);
    assign key_open = wr_key & armed_q & (wbyte == `WTA_KEY_SECOND); // see [R1]

    // Disarm on the last allowed clock, so a 55H one clock late never opens the window.
    always @(posedge clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            gap_q   <= 4'h0;
            win_q   <= 4'h0;
        end else begin
            if (wr_key) begin
                armed_q <= (wbyte == `WTA_KEY_FIRST);                 // see [R16]
                gap_q   <= 4'h0;
            end else if (armed_q) begin
                if (gap_q == GAP_LAST)
                    armed_q <= 1'b0;                                  // see [R15]
                else
                    gap_q <= gap_q + 4'h1;
            end
            if (key_open)
                win_q <= WIN_LEN;                                     // see [R2]
            else if (win_open)
                win_q <= win_q - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog control register and software control bits
    // ------------------------------------------------------------------
    reg        baud_dbl_q;
    reg        pwr_up_q;
    reg        wd_irqf_q;
    reg        cause_q;
    reg        rst_en_q;
    reg        kick_q;
    reg        irq_en_q;
    reg        movx_q;
    wire       prot_wr;
    wire       timeout_evt;
    wire       dog_rst_evt;
    wire [7:0] wdc_val;

    assign prot_wr = wr_wdc & win_open;
    assign wdc_val = {baud_dbl_q, pwr_up_q, 2'b00, wd_irqf_q, cause_q, rst_en_q, kick_q};
    assign port1_baud_double = baud_dbl_q;                            // see [R13]
    assign movx_wait_enable  = movx_q;

    // Hardware sets beat software clears in the same cycle.
    always @(posedge clk) begin
        if (!rst_n) begin
            baud_dbl_q <= 1'b0;
            pwr_up_q   <= 1'b1;                                       // see [R12]
            wd_irqf_q  <= 1'b0;
            cause_q    <= 1'b0;
            rst_en_q   <= 1'b0;                                       // see [R12]
            kick_q     <= 1'b0;
            irq_en_q   <= 1'b0;
            movx_q     <= 1'b0;
        end else if (ext_rst_evt) begin
            baud_dbl_q <= 1'b0;                                       // see [R11]
            wd_irqf_q  <= 1'b0;
            kick_q     <= 1'b0;
        end else begin
            if (wr_wdc)
                baud_dbl_q <= wbyte[`WTA_WD_BAUD_DOUBLE];             // see [R13]
            if (prot_wr)
                pwr_up_q <= wbyte[`WTA_WD_POWER_UP];                  // see [R5]
            if (prot_wr)
                rst_en_q <= wbyte[`WTA_WD_RESET_EN];                  // see [R3]
            if (timeout_evt)
                wd_irqf_q <= 1'b1;                                    // see [R6]
            else if (prot_wr)
                wd_irqf_q <= wbyte[`WTA_WD_IRQ_FLAG];
            if (dog_rst_evt)
                cause_q <= 1'b1;                                      // see [R7]
            else if (pfail_evt)
                cause_q <= 1'b0;
            else if (wr_wdc)
                cause_q <= wbyte[`WTA_WD_RESET_CAUSE];
            kick_q <= prot_wr & wbyte[`WTA_WD_KICK];                  // see [R9]
            if (wr_ctrl)
                irq_en_q <= wbyte[`WTA_CTRL_IRQ_EN];
            if (wr_ctrl && win_open)
                movx_q <= wbyte[`WTA_CTRL_MOVX_WAIT];                 // see [R14]
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter and pre-reset delay
    // ------------------------------------------------------------------
    reg        wd_state_q;
    reg [31:0] wd_cnt_q;
    reg [9:0]  pre_q;
    reg        dog_rst_q;

    assign timeout_evt   = (wd_state_q == WD_RUN) & ~kick_q & (wd_cnt_q == TO_LAST);
    assign dog_rst_evt   = (wd_state_q == WD_PRE) & ~kick_q & (pre_q == PRE_LAST) & rst_en_q;
    assign dog_reset_out = dog_rst_q;
    assign dog_irq_out   = wd_irqf_q & irq_en_q;                      // see [R10]

    // A kick during the pre-reset delay still saves the device.
    always @(posedge clk) begin
        if (!rst_n) begin
            wd_state_q <= WD_RUN;
            wd_cnt_q   <= 32'h0000_0000;
            pre_q      <= 10'h000;
            dog_rst_q  <= 1'b0;
        end else begin
            dog_rst_q <= dog_rst_evt;                                 // see [R8]
            if (kick_q || ext_rst_evt) begin
                wd_state_q <= WD_RUN;                                 // see [R9]
                wd_cnt_q   <= 32'h0000_0000;
                pre_q      <= 10'h000;
            end else begin
                case (wd_state_q)
                    WD_RUN: begin
                        if (wd_cnt_q == TO_LAST) begin                // see [R17]
                            wd_state_q <= WD_PRE;
                            pre_q      <= 10'h000;
                        end else begin
                            wd_cnt_q <= wd_cnt_q + 32'h1;
                        end
                    end
                    WD_PRE: begin
                        if (pre_q == PRE_LAST) begin                  // see [R10]
                            wd_state_q <= WD_RUN;
                            wd_cnt_q   <= 32'h0000_0000;
                        end else begin
                            pre_q <= pre_q + 10'h001;
                        end
                    end
                    default: begin
                        wd_state_q <= WD_RUN;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, clear and enable
    // ------------------------------------------------------------------
    reg  [`WTA_EV_BITS-1:0] ist_q;
    reg  [`WTA_EV_BITS-1:0] ien_q;
    wire [`WTA_EV_BITS-1:0] ev;
    wire [`WTA_EV_BITS-1:0] clr_mask;

    assign ev[`WTA_EV_TIMEOUT]   = timeout_evt;
    assign ev[`WTA_EV_DOG_RESET] = dog_rst_evt;
    assign ev[`WTA_EV_UNLOCKED]  = key_open;
    assign ev[`WTA_EV_REFUSED]   = (wr_wdc | wr_ctrl) & ~win_open;
    assign clr_mask = wr_clr ? wbyte[`WTA_EV_BITS-1:0] : {`WTA_EV_BITS{1'b0}};
    assign irq      = |(ist_q & ien_q);

    // New events are ORed in after the clear so none is lost.
    always @(posedge clk) begin
        if (!rst_n) begin
            ist_q <= {`WTA_EV_BITS{1'b0}};
            ien_q <= {`WTA_EV_BITS{1'b0}};
        end else begin
            ist_q <= (ist_q & ~clr_mask) | ev;
            if (wr_ien)
                ien_q <= wbyte[`WTA_EV_BITS-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Write decode and read mux
    // ------------------------------------------------------------------
    // Write decode; the key register is write-only and reads as zero.
    always @* begin
        case (awaddr_q)
            `WTA_ADDR_UNLOCK_KEY: wr_hit = 1'b1;
            `WTA_ADDR_WD_CONTROL: wr_hit = 1'b1;
            `WTA_ADDR_CTRL:       wr_hit = 1'b1;
            `WTA_ADDR_IRQ_CLEAR:  wr_hit = 1'b1;
            `WTA_ADDR_IRQ_ENABLE: wr_hit = 1'b1;
            default:              wr_hit = 1'b0;
        endcase
    end

    // Reads need no unlock and have no side effects.
    always @* begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `WTA_ADDR_UNLOCK_KEY: rd_val = 32'h0000_0000;
            `WTA_ADDR_WD_CONTROL: rd_val = {24'h00_0000, wdc_val};    // see [R4]
            `WTA_ADDR_CTRL:       rd_val = {30'h0000_0000, movx_q, irq_en_q};
            `WTA_ADDR_IRQ_STATUS: rd_val = {28'h000_0000, ist_q};
            `WTA_ADDR_IRQ_CLEAR:  rd_val = 32'h0000_0000;
            `WTA_ADDR_IRQ_ENABLE: rd_val = {28'h000_0000, ien_q};
            `WTA_ADDR_WD_COUNT:   rd_val = wd_cnt_q;
            default:              rd_hit = 1'b0;
        endcase
    end

endmodule

//--- verification/wta_top_props.sv
// Concurrent checks on the bus handshakes and control outputs of the watchdog block.
`timescale 1ns/1ps
module wta_top_props (
    input logic        clk,
    input logic        rst_n,
    input logic        ext_rst_pin,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        dog_reset_out,
    input logic        port1_baud_double,
    input logic        movx_wait_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Recent external reset pin history, as its event lands late.
    logic [7:0] ext_hist_q;
    logic       ext_recent;
    always_ff @(posedge clk) begin
        ext_hist_q <= {ext_hist_q[6:0], ext_rst_pin};
    end
    assign ext_recent = |ext_hist_q;

    // ------------------------------------------------------------
    // Handshake steps
    // ------------------------------------------------------------
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_w_answer;
        s_wr_taken |-> ##2 s_axi_bvalid;
    endproperty
    property p_r_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_reset_pulse;
        $rose(dog_reset_out) |=> !dog_reset_out [*8];
    endproperty
    property p_baud_src;
        $changed(port1_baud_double) |-> s_axi_bvalid || ext_recent;
    endproperty
    property p_movx_src;
        $changed(movx_wait_enable) |-> s_axi_bvalid;
    endproperty

    a_b_hold:      assert property (p_b_hold) else $error("write response dropped early");
    a_r_hold:      assert property (p_r_hold) else $error("read data dropped early");
    a_w_answer:    assert property (p_w_answer) else $error("no write response");
    a_r_answer:    assert property (p_r_answer) else $error("no read answer");
    a_ar_block:    assert property (p_ar_block) else $error("read taken while answer pending");
    a_aw_block:    assert property (p_aw_block) else $error("write taken while answer pending");
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset request too long");
    a_baud_src:    assert property (p_baud_src) else $error("baud bit moved on its own");
    a_movx_src:    assert property (p_movx_src) else $error("wait enable moved on its own");
endmodule

bind wta_top wta_top_props u_wta_top_props (.*);

//--- verification/wta_top_tb.sv
// Self-checking bench for the watchdog block with timed-access unlock.
`timescale 1ns/1ps
`include "wta_consts.vh"
module wta_top_tb;
    localparam int          TO  = 2000;
    localparam logic [11:0] KEY = `WTA_ADDR_UNLOCK_KEY;
    localparam logic [11:0] WDC = `WTA_ADDR_WD_CONTROL;
    localparam logic [11:0] CTL = `WTA_ADDR_CTRL;
    localparam logic [11:0] IST = `WTA_ADDR_IRQ_STATUS;
    localparam logic [11:0] ICL = `WTA_ADDR_IRQ_CLEAR;
    localparam logic [11:0] IEN = `WTA_ADDR_IRQ_ENABLE;
    logic        clk = 0, rst_n = 0, ext_rst_pin = 0, pfail_pin = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        dog_reset_out, dog_irq_out, port1_baud_double, movx_wait_enable, irq;
    int          errors = 0, check_count = 0, cycles = 0, n;

    wta_top #(.TIMEOUT_CLKS(TO)) u_wta_top (.*);

    // Clock at 200 MHz.
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Hang guard; the longest path is two time-outs plus the reset delay.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 15000) begin
            errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        s_axi_bready <= 1'b1;
        @(posedge clk);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Ready is raised only after valid is seen, so a held answer is exercised.
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clk);
        s_axi_rready <= 1'b1;
        @(posedge clk);
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(nm, s_axi_rdata, e);
    endtask

    task automatic unlock();
        wr(KEY, `WTA_KEY_FIRST);
        wr(KEY, `WTA_KEY_SECOND);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rc("wdc_reset", WDC, 32'h40);
        rc("unmapped", 12'h7fc, 32'h0);
        chk("unmapped_resp", {30'h0, last_resp}, {30'h0, `WTA_RESP_SLVERR});
        wr(IEN, 8'h01);
        chk("wr_resp", {30'h0, last_resp}, {30'h0, `WTA_RESP_OKAY});
        wr(WDC, 8'h83);
        chk("baud_on", {31'h0, port1_baud_double}, 32'h1);
        rc("wdc_locked", WDC, 32'hc0);
        wr(WDC, 8'h00);
        rc("wdc_por_kept", WDC, 32'h40);
        rc("refused_status", IST, 32'h08);
        $display("test locked done");
        unlock();
        wr(WDC, 8'h42);
        rc("wdc_unlocked", WDC, 32'h42);
        unlock();
        // The write below commits on the first clock after the window.
        repeat (`WTA_WINDOW_CLKS - 4) @(posedge clk);
        wr(WDC, 8'h40);
        rc("window_closed", WDC, 32'h42);
        wr(KEY, `WTA_KEY_FIRST);
        // The second key commits one clock past the allowed gap.
        repeat (`WTA_KEY_GAP_CLKS - 4) @(posedge clk);
        wr(KEY, `WTA_KEY_SECOND);
        wr(WDC, 8'h40);
        rc("late_key", WDC, 32'h42);
        wr(KEY, `WTA_KEY_FIRST);
        wr(KEY, 8'h5a);
        wr(KEY, `WTA_KEY_SECOND);
        wr(WDC, 8'h40);
        rc("wrong_key", WDC, 32'h42);
        wr(KEY, `WTA_KEY_SECOND);
        wr(KEY, `WTA_KEY_FIRST);
        wr(WDC, 8'h40);
        rc("reversed_keys", WDC, 32'h42);
        repeat (`WTA_KEY_GAP_CLKS + 2) @(posedge clk);
        wr(CTL, 8'h03);
        chk("movx_locked", {31'h0, movx_wait_enable}, 32'h0);
        unlock();
        wr(CTL, 8'h03);
        chk("movx_open", {31'h0, movx_wait_enable}, 32'h1);
        $display("test unlock done");
        // First time-out with the reset enabled.
        while (dog_irq_out !== 1'b1) @(posedge clk);
        n = 0;
        while (dog_reset_out !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("reset_delay", n, 32'd512);
        rc("wdc_dog_reset", WDC, 32'h4e);
        rc("status_events", IST, 32'h0f);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        $display("test timeout done");
        // Kick, then a second time-out with the reset disabled.
        unlock();
        wr(WDC, 8'h41);
        rc("wdc_kicked", WDC, 32'h40);
        wr(ICL, 8'h0f);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        repeat (TO - 200) @(posedge clk);
        chk("no_early_timeout", {31'h0, dog_irq_out}, 32'h0);
        while (dog_irq_out !== 1'b1) @(posedge clk);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (dog_reset_out === 1'b1) n++;
        end
        chk("no_dog_reset", n, 32'd0);
        rc("wdc_flag_only", WDC, 32'h48);
        chk("irq_again", {31'h0, irq}, 32'h1);
        wr(IEN, 8'h00);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        wr(IEN, 8'h01);
        wr(ICL, 8'h01);
        chk("irq_off", {31'h0, irq}, 32'h0);
        rc("status_clear", IST, 32'h00);
        $display("test kick done");
        // External and power-fail resets.
        unlock();
        wr(WDC, 8'hc6);
        rc("wdc_before_ext", WDC, 32'hc6);
        ext_rst_pin <= 1'b1;
        repeat (8) @(posedge clk);
        ext_rst_pin <= 1'b0;
        repeat (8) @(posedge clk);
        rc("wdc_ext_reset", WDC, 32'h46);
        pfail_pin <= 1'b1;
        repeat (8) @(posedge clk);
        pfail_pin <= 1'b0;
        repeat (8) @(posedge clk);
        rc("wdc_pfail", WDC, 32'h42);
        $display("test resets done");
        wrap_up();
    end
endmodule
